// ### sr_params.svh
// constants of the special register bank
`ifndef SR_PARAMS_SVH
`define SR_PARAMS_SVH

// ****************************************
// register indices (byte address is four times the index)
// ****************************************
`define SR_IDX_IRQ_STATUS 8'h00
`define SR_IDX_IRQ_MASK 8'h01
`define SR_IDX_POINTER_LOW 8'h82
`define SR_IDX_POINTER_HIGH 8'h83
`define SR_IDX_KEYPAD_MASK 8'h86
`define SR_IDX_KEYPAD_PATTERN 8'h93
`define SR_IDX_KEYPAD_CONTROL 8'h94
`define SR_IDX_CPU_CLOCK_DIVIDER 8'h95
`define SR_IDX_AUXILIARY_FUNCTION 8'hA2
`define SR_IDX_INTERRUPT_ENABLE_FIRST 8'hA8
`define SR_IDX_CAPTURE_A_LOW 8'hAA
`define SR_IDX_CAPTURE_A_HIGH 8'hAB
`define SR_IDX_COMPARATOR_ONE 8'hAC
`define SR_IDX_COMPARATOR_TWO 8'hAD
`define SR_IDX_CAPTURE_SECOND_LOW 8'hAE
`define SR_IDX_CAPTURE_SECOND_HIGH 8'hAF
`define SR_IDX_PRIORITY_FIRST_UPPER 8'hB7
`define SR_IDX_PRIORITY_FIRST 8'hB8
`define SR_IDX_BAUD_CONTROL 8'hBD
`define SR_IDX_BAUD_RATE_LOW 8'hBE
`define SR_IDX_BAUD_RATE_HIGH 8'hBF
`define SR_IDX_TWO_WIRE_CONTROL 8'hD8
`define SR_IDX_TWO_WIRE_STATUS 8'hD9
`define SR_IDX_TWO_WIRE_DATA 8'hDA
`define SR_IDX_TWO_WIRE_OWN_ADDRESS 8'hDB
`define SR_IDX_TWO_WIRE_CLOCK_LOW 8'hDC
`define SR_IDX_TWO_WIRE_CLOCK_HIGH 8'hDD
`define SR_IDX_MAIN_ARITH 8'hE0
`define SR_IDX_INTERRUPT_ENABLE_SECOND 8'hE8
`define SR_IDX_CAPTURE_COMPARE_A 8'hEA
`define SR_IDX_CAPTURE_COMPARE_SECOND 8'hEB
`define SR_IDX_COMPARE_THIRD 8'hEC
`define SR_IDX_COMPARE_FOURTH 8'hED
`define SR_IDX_OUTPUT_COMPARE_A_LOW 8'hEE
`define SR_IDX_OUTPUT_COMPARE_A_HIGH 8'hEF
`define SR_IDX_SECOND_OPERAND 8'hF0
`define SR_IDX_EEPROM_CONTROL 8'hF1
`define SR_IDX_EEPROM_DATA 8'hF2
`define SR_IDX_EEPROM_ADDRESS 8'hF3
`define SR_IDX_PRIORITY_SECOND_UPPER 8'hF7
`define SR_IDX_PRIORITY_SECOND 8'hF8

// ****************************************
// reset values
// ****************************************
`define SR_RST_ZERO 8'h00
`define SR_RST_KEYPAD_PATTERN 8'hFF
`define SR_RST_TWO_WIRE_STATUS 8'hF8
`define SR_RST_EEPROM_CONTROL 8'h0E

// ****************************************
// field positions and bus layout
// ****************************************
`define SR_BIT_SPACE_SEL 10
`define SR_BIT_KEYPAD_FLAG 0
`define SR_BIT_COMPARATOR_OUT 1
`define SR_BIT_COMPARATOR_FLAG 0
`define SR_BIT_EEPROM_FLAG 7
`define SR_BIT_EEPROM_HV_ERROR 6
`define SR_BIT_TWO_WIRE_FLAG 3
`define SR_BIT_SOFTWARE_RESET 3
`define SR_BIT_POINTER_SELECT 0
`define SR_BIT_BAUD_ENABLE 0
`define SR_BIT_BAUD_SOURCE 1
`define SR_BIT_PATTERN_SELECT 1
`define SR_BIT_COMPARATOR_ENABLE 5
`define SR_MASK_TWO_WIRE_STATE 8'hF8
`define SR_IRQ_KEYPAD 0
`define SR_IRQ_CMP_ONE 1
`define SR_IRQ_CMP_TWO 2
`define SR_IRQ_EEPROM 3
`define SR_IRQ_TWO_WIRE 4
`define SR_IRQ_UNMAPPED 5
`define SR_IRQ_BITS 6

`endif

// ### sr_pkg.sv
// types of the special register bank
package sr_pkg;

    typedef struct packed {
        logic defined;
        logic bit_addressable;
        logic [7:0] rst;
        logic [7:0] wmask;
        logic [7:0] rmask;
        logic [7:0] ones;
    } sr_info_t;

    typedef struct packed {
        logic [15:0] capture_a;
        logic [15:0] capture_second;
        logic [7:0] two_wire_state;
        logic comparator_one_out;
        logic comparator_two_out;
        logic eeprom_hv_error;
    } sr_stat_t;

    typedef struct packed {
        logic keypad;
        logic comparator_one;
        logic comparator_two;
        logic eeprom_done;
        logic two_wire;
    } sr_evt_t;

    typedef struct packed {
        logic [15:0] data_pointer_pair;
        logic pointer_select;
        logic baud_generator_enable;
        logic serial_baud_source;
        logic [7:0] keypad_mask;
        logic [7:0] keypad_pattern;
        logic pattern_match_select;
        logic comparator_one_enable;
        logic comparator_two_enable;
        logic [7:0] capture_compare_a_control;
        logic [7:0] main_arith_register;
    } sr_ctrl_t;

endpackage

// ### sr_bank.sv
// special register bank behind an apb slave
// ****************************************
// ****************************************
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "sr_params.svh"

module sr_bank (
    input wire logic MCLK_IN,
    input wire logic RST_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [11:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    input wire logic [3:0] PSTRB_IN,
    input wire sr_pkg::sr_stat_t STAT_IN,
    input wire sr_pkg::sr_evt_t EVT_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    output logic IRQ_OUT,
    output logic SOFT_RESET_OUT,
    output sr_pkg::sr_ctrl_t CTRL_OUT
);
    import sr_pkg::*;

    // ****************************************
    // register map description
    // ****************************************
    function automatic sr_info_t reg_info(input logic [7:0] idx);
        sr_info_t i;
        i = '{1'b1, 1'b0, `SR_RST_ZERO, 8'hFF, 8'hFF, 8'h00};
        case (idx)
            `SR_IDX_POINTER_LOW,
            `SR_IDX_POINTER_HIGH : ;
            `SR_IDX_KEYPAD_MASK : ;
            `SR_IDX_CPU_CLOCK_DIVIDER,
            `SR_IDX_BAUD_RATE_LOW,
            `SR_IDX_BAUD_RATE_HIGH : ;
            `SR_IDX_TWO_WIRE_DATA,
            `SR_IDX_TWO_WIRE_OWN_ADDRESS : ;
            `SR_IDX_TWO_WIRE_CLOCK_LOW,
            `SR_IDX_TWO_WIRE_CLOCK_HIGH : ;
            `SR_IDX_CAPTURE_COMPARE_SECOND : ;
            `SR_IDX_OUTPUT_COMPARE_A_LOW,
            `SR_IDX_OUTPUT_COMPARE_A_HIGH : ;
            `SR_IDX_EEPROM_DATA,
            `SR_IDX_EEPROM_ADDRESS : ;
            `SR_IDX_CAPTURE_COMPARE_A : ;
            `SR_IDX_MAIN_ARITH,
            `SR_IDX_SECOND_OPERAND,
            `SR_IDX_INTERRUPT_ENABLE_FIRST,
            `SR_IDX_PRIORITY_FIRST : begin
                i.bit_addressable = 1'b1;
                if (idx == `SR_IDX_PRIORITY_FIRST) begin
                    i.wmask = 8'h7F;
                    i.rmask = 8'h7F;
                end
            end
            `SR_IDX_INTERRUPT_ENABLE_SECOND,
            `SR_IDX_PRIORITY_SECOND : begin
                i.bit_addressable = 1'b1;
                i.wmask = 8'hDF;
                i.rmask = 8'hDF;
            end
            `SR_IDX_PRIORITY_SECOND_UPPER : begin
                i.wmask = 8'hDF;
                i.rmask = 8'hDF;
            end
            `SR_IDX_KEYPAD_PATTERN : i.rst = `SR_RST_KEYPAD_PATTERN;
            `SR_IDX_KEYPAD_CONTROL : begin
                i.wmask = 8'h03;
                i.rmask = 8'h03;
            end
            `SR_IDX_AUXILIARY_FUNCTION : begin
                i.wmask = 8'hF1;
                i.rmask = 8'hF1;
            end
            `SR_IDX_CAPTURE_A_LOW,
            `SR_IDX_CAPTURE_A_HIGH,
            `SR_IDX_CAPTURE_SECOND_LOW,
            `SR_IDX_CAPTURE_SECOND_HIGH,
            `SR_IDX_TWO_WIRE_STATUS : begin
                i.wmask = 8'h00;
                i.rmask = 8'h00;
            end
            `SR_IDX_COMPARATOR_ONE,
            `SR_IDX_COMPARATOR_TWO : begin
                i.wmask = 8'h3D;
                i.rmask = 8'h3D;
            end
            `SR_IDX_PRIORITY_FIRST_UPPER : begin
                i.wmask = 8'h7F;
                i.rmask = 8'h7F;
            end
            `SR_IDX_BAUD_CONTROL : begin
                i.wmask = 8'h03;
                i.rmask = 8'h03;
            end
            `SR_IDX_TWO_WIRE_CONTROL : begin
                i.bit_addressable = 1'b1;
                i.wmask = 8'h7D;
                i.rmask = 8'h7D;
            end
            `SR_IDX_COMPARE_THIRD,
            `SR_IDX_COMPARE_FOURTH : begin
                i.wmask = 8'h07;
                i.rmask = 8'h07;
            end
            `SR_IDX_EEPROM_CONTROL : begin
                i.rst = `SR_RST_EEPROM_CONTROL & 8'hB1;
                i.wmask = 8'hB1;
                i.rmask = 8'hB1;
                i.ones = `SR_RST_EEPROM_CONTROL;
            end
            default : i = '{1'b0, 1'b0, 8'h00, 8'h00, 8'h00, 8'h00};
        endcase
        return i;
    endfunction

    function automatic logic [7:0] reset_value(input logic [6:0] slot);
        sr_info_t i;
        i = reg_info({1'b1, slot});
        return i.rst;
    endfunction

    // ****************************************
    // access decode
    // ****************************************
    logic [7:0] store_reg [0:127];
    logic [`SR_IRQ_BITS-1:0] irq_status_reg;
    logic [`SR_IRQ_BITS-1:0] irq_mask_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic irq_reg;
    logic soft_reset_reg;
    sr_ctrl_t ctrl_reg;

    logic bit_space;
    logic [7:0] bit_addr;
    logic [7:0] idx;
    sr_info_t info;
    logic is_own;
    logic hit;
    logic setup;
    logic wr_done;
    logic [7:0] rbyte;
    logic [31:0] rd_next;
    logic [7:0] wbyte;
    logic [7:0] wen;
    logic [`SR_IRQ_BITS-1:0] irq_events;
    logic own_wr;
    logic status_wr;
    logic mask_wr;
    logic soft_hit;

    always_comb begin
        bit_space = PADDR_IN[`SR_BIT_SPACE_SEL];
        bit_addr = PADDR_IN[9:2];
        idx = bit_space ? {bit_addr[7:3], 3'b000} : bit_addr;
        info = reg_info(idx);
        is_own = !bit_space
            && (idx == `SR_IDX_IRQ_STATUS || idx == `SR_IDX_IRQ_MASK);
        hit = is_own
            || (info.defined && (!bit_space || info.bit_addressable));
        setup = PSEL_IN && !PENABLE_IN;
        wr_done = PSEL_IN && PENABLE_IN && pready_reg && PWRITE_IN && hit;
    end

    // ****************************************
    // own register and software reset strobes
    // ****************************************
    always_comb begin
        own_wr = wr_done && is_own && PSTRB_IN[0];
        status_wr = own_wr && idx == `SR_IDX_IRQ_STATUS;
        mask_wr = own_wr && idx == `SR_IDX_IRQ_MASK;
        soft_hit = wr_done && !bit_space && PSTRB_IN[0]
            && idx == `SR_IDX_AUXILIARY_FUNCTION
            && PWDATA_IN[`SR_BIT_SOFTWARE_RESET];
    end

    // ****************************************
    // read data path
    // ****************************************
    always_comb begin
        rbyte = (store_reg[idx[6:0]] & info.rmask) | info.ones;
        case (idx)
            `SR_IDX_CAPTURE_A_LOW : rbyte = STAT_IN.capture_a[7:0];
            `SR_IDX_CAPTURE_A_HIGH : rbyte = STAT_IN.capture_a[15:8];
            `SR_IDX_CAPTURE_SECOND_LOW : rbyte = STAT_IN.capture_second[7:0];
            `SR_IDX_CAPTURE_SECOND_HIGH : rbyte = STAT_IN.capture_second[15:8];
            `SR_IDX_TWO_WIRE_STATUS : rbyte = STAT_IN.two_wire_state & `SR_MASK_TWO_WIRE_STATE;
            `SR_IDX_COMPARATOR_ONE : rbyte[`SR_BIT_COMPARATOR_OUT] = STAT_IN.comparator_one_out;
            `SR_IDX_COMPARATOR_TWO : rbyte[`SR_BIT_COMPARATOR_OUT] = STAT_IN.comparator_two_out;
            `SR_IDX_EEPROM_CONTROL : rbyte[`SR_BIT_EEPROM_HV_ERROR] = STAT_IN.eeprom_hv_error;
            default : ;
        endcase
        rd_next = 32'h0000_0000;
        if (is_own) begin
            rd_next[`SR_IRQ_BITS-1:0] = (idx == `SR_IDX_IRQ_STATUS) ? irq_status_reg : irq_mask_reg;
        end else if (hit && bit_space) begin
            rd_next[0] = rbyte[bit_addr[2:0]];
        end else if (hit) begin
            rd_next[7:0] = rbyte;
        end
    end

    // ****************************************
    // apb answer, zero wait states
    // ****************************************
    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            pready_reg <= 1'b0;
        end else begin
            pready_reg <= setup;
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            pslverr_reg <= 1'b0;
        end else begin
            pslverr_reg <= setup && !hit;
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            prdata_reg <= 32'h0000_0000;
        end else if (setup) begin
            prdata_reg <= PWRITE_IN ? 32'h0000_0000 : rd_next;
        end
    end

    // ****************************************
    // register storage with hardware flags
    // ****************************************
    always_comb begin
        wbyte = PWDATA_IN[7:0];
        wen = info.wmask;
        if (bit_space) begin
            wbyte = {8{PWDATA_IN[0]}};
            wen = info.wmask & (8'h01 << bit_addr[2:0]);
        end
        if (!PSTRB_IN[0] || is_own || !wr_done) begin
            wen = 8'h00;
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            for (int k = 0; k < 128; k++) begin
                store_reg[k] <= reset_value(7'(k));
            end
        end else begin
            store_reg[idx[6:0]] <= (store_reg[idx[6:0]] & ~wen) | (wbyte & wen);
            if (EVT_IN.keypad) begin
                store_reg[7'(`SR_IDX_KEYPAD_CONTROL)][`SR_BIT_KEYPAD_FLAG] <= 1'b1;
            end
            if (EVT_IN.comparator_one) begin
                store_reg[7'(`SR_IDX_COMPARATOR_ONE)][`SR_BIT_COMPARATOR_FLAG] <= 1'b1;
            end
            if (EVT_IN.comparator_two) begin
                store_reg[7'(`SR_IDX_COMPARATOR_TWO)][`SR_BIT_COMPARATOR_FLAG] <= 1'b1;
            end
            if (EVT_IN.eeprom_done) begin
                store_reg[7'(`SR_IDX_EEPROM_CONTROL)][`SR_BIT_EEPROM_FLAG] <= 1'b1;
            end
            if (EVT_IN.two_wire) begin
                store_reg[7'(`SR_IDX_TWO_WIRE_CONTROL)][`SR_BIT_TWO_WIRE_FLAG] <= 1'b1;
            end
        end
    end

    // ****************************************
    // software reset pulse
    // ****************************************
    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            soft_reset_reg <= 1'b0;
        end else begin
            soft_reset_reg <= soft_hit;
        end
    end

    // ****************************************
    // interrupt status and mask
    // ****************************************
    always_comb begin
        irq_events = '0;
        irq_events[`SR_IRQ_KEYPAD] = EVT_IN.keypad;
        irq_events[`SR_IRQ_CMP_ONE] = EVT_IN.comparator_one;
        irq_events[`SR_IRQ_CMP_TWO] = EVT_IN.comparator_two;
        irq_events[`SR_IRQ_EEPROM] = EVT_IN.eeprom_done;
        irq_events[`SR_IRQ_TWO_WIRE] = EVT_IN.two_wire;
        irq_events[`SR_IRQ_UNMAPPED] = PSEL_IN && PENABLE_IN && pready_reg && !hit;
    end

    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            irq_status_reg <= '0;
            irq_mask_reg <= '0;
            irq_reg <= 1'b0;
        end else begin
            if (status_wr) begin
                irq_status_reg <= (irq_status_reg & ~PWDATA_IN[`SR_IRQ_BITS-1:0]) | irq_events;
            end else begin
                irq_status_reg <= irq_status_reg | irq_events;
            end
            if (mask_wr) begin
                irq_mask_reg <= PWDATA_IN[`SR_IRQ_BITS-1:0];
            end
            irq_reg <= |(irq_status_reg & irq_mask_reg);
        end
    end

    // ****************************************
    // control outputs
    // ****************************************
    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            ctrl_reg <= '0;
            ctrl_reg.keypad_pattern <= `SR_RST_KEYPAD_PATTERN;
        end else begin
            ctrl_reg.data_pointer_pair <= {store_reg[7'(`SR_IDX_POINTER_HIGH)],
                store_reg[7'(`SR_IDX_POINTER_LOW)]};
            ctrl_reg.pointer_select <=
                store_reg[7'(`SR_IDX_AUXILIARY_FUNCTION)][`SR_BIT_POINTER_SELECT];
            ctrl_reg.baud_generator_enable <=
                store_reg[7'(`SR_IDX_BAUD_CONTROL)][`SR_BIT_BAUD_ENABLE];
            ctrl_reg.serial_baud_source <=
                store_reg[7'(`SR_IDX_BAUD_CONTROL)][`SR_BIT_BAUD_SOURCE];
            ctrl_reg.keypad_mask <= store_reg[7'(`SR_IDX_KEYPAD_MASK)];
            ctrl_reg.keypad_pattern <= store_reg[7'(`SR_IDX_KEYPAD_PATTERN)];
            ctrl_reg.pattern_match_select <=
                store_reg[7'(`SR_IDX_KEYPAD_CONTROL)][`SR_BIT_PATTERN_SELECT];
            ctrl_reg.comparator_one_enable <=
                store_reg[7'(`SR_IDX_COMPARATOR_ONE)][`SR_BIT_COMPARATOR_ENABLE];
            ctrl_reg.comparator_two_enable <=
                store_reg[7'(`SR_IDX_COMPARATOR_TWO)][`SR_BIT_COMPARATOR_ENABLE];
            ctrl_reg.capture_compare_a_control <= store_reg[7'(`SR_IDX_CAPTURE_COMPARE_A)];
            ctrl_reg.main_arith_register <= store_reg[7'(`SR_IDX_MAIN_ARITH)];
        end
    end

    always_comb begin
        PRDATA_OUT = prdata_reg;
        PREADY_OUT = pready_reg;
        PSLVERR_OUT = pslverr_reg;
        IRQ_OUT = irq_reg;
        SOFT_RESET_OUT = soft_reset_reg;
        CTRL_OUT = ctrl_reg;
    end

endmodule
`default_nettype wire

// ### sr_bank_props.sv
// concurrent checks on the special register bank ports
`timescale 1ns/1ps
`default_nettype none
module sr_bank_props (
    input wire logic MCLK_IN,
    input wire logic RST_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [11:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    input wire logic [3:0] PSTRB_IN,
    input wire logic [31:0] PRDATA_OUT,
    input wire logic PREADY_OUT,
    input wire logic PSLVERR_OUT,
    input wire logic IRQ_OUT,
    input wire logic SOFT_RESET_OUT,
    input wire sr_pkg::sr_ctrl_t CTRL_OUT
);
    import sr_pkg::*;
    // ********
    // bus answer and field checks
    // ********
    logic rd_ack;
    logic wr_ack;
    assign rd_ack = PREADY_OUT && !PWRITE_IN;
    assign wr_ack = PREADY_OUT && PWRITE_IN && PSTRB_IN[0];
    default clocking @(posedge MCLK_IN); endclocking
    default disable iff (RST_IN);
    AST_READY_AFTER_SETUP: assert property (
        PSEL_IN && !PENABLE_IN |=> PREADY_OUT) else $error("no ready after setup");
    AST_READY_PULSE: assert property (
        PREADY_OUT |-> PSEL_IN && PENABLE_IN ##1 !PREADY_OUT) else $error("ready not a pulse");
    AST_ERR_WITH_READY: assert property (
        PSLVERR_OUT |-> PREADY_OUT && PRDATA_OUT == 32'h0000_0000) else $error("bad error");
    AST_UPPER_ZERO: assert property (
        PREADY_OUT |-> PRDATA_OUT[31:8] == 24'h00_0000) else $error("upper read bits set");
    AST_RESET_CONTROL: assert property (
        $fell(RST_IN) |-> CTRL_OUT.keypad_pattern == 8'hFF && CTRL_OUT.keypad_mask == 8'h00
        && CTRL_OUT.data_pointer_pair == 16'h0000) else $error("control reset values");
    AST_AUX_FIXED: assert property (
        rd_ack && PADDR_IN == 12'h288 |-> PRDATA_OUT[3:2] == 2'b00) else $error("aux bits");
    AST_BAUD_RESERVED: assert property (
        rd_ack && PADDR_IN == 12'h2F4 |-> PRDATA_OUT[7:2] == 6'h00) else $error("baud bits");
    AST_CMP_RESERVED: assert property (
        rd_ack && PADDR_IN == 12'h2B0 |-> PRDATA_OUT[7:6] == 2'b00) else $error("cmp bits");
    AST_KEYPAD_RESERVED: assert property (
        rd_ack && PADDR_IN == 12'h250 |-> PRDATA_OUT[7:2] == 6'h00) else $error("keypad bits");
    AST_PRIO_RESERVED: assert property (
        rd_ack && PADDR_IN == 12'h2DC |-> !PRDATA_OUT[7]) else $error("priority bit 7");
    AST_EEPROM_ONES: assert property (
        rd_ack && PADDR_IN == 12'h3C4 |-> PRDATA_OUT[3:1] == 3'h7) else $error("eeprom ones");
    AST_SOFT_RESET: assert property (
        wr_ack && PADDR_IN == 12'h288 && PWDATA_IN[3] |=> SOFT_RESET_OUT ##1 !SOFT_RESET_OUT)
        else $error("soft reset pulse");
    AST_POINTER_HIGH: assert property (
        wr_ack && PADDR_IN == 12'h20C |-> ##2
        CTRL_OUT.data_pointer_pair[15:8] == $past(PWDATA_IN[7:0], 2)) else $error("pointer");
    cover property (wr_ack && PADDR_IN == 12'h288 && PWDATA_IN[3]);
    cover property (PSLVERR_OUT);
    cover property ($rose(IRQ_OUT));
endmodule
`default_nettype wire

// ### sr_core_model.sv
// processor side model driving the register bus
`timescale 1ns/1ps
`default_nettype none
module sr_core_model (
    input wire logic clk_in,
    input wire logic [31:0] prdata_in,
    input wire logic pready_in,
    input wire logic pslverr_in,
    output logic psel_out,
    output logic penable_out,
    output logic pwrite_out,
    output logic [11:0] paddr_out,
    output logic [31:0] pwdata_out,
    output logic [3:0] pstrb_out
);
    import sr_pkg::*;
    // ********
    // one transfer, held until ready
    // ********
    initial begin
        psel_out = 1'b0;
        penable_out = 1'b0;
        pwrite_out = 1'b0;
        paddr_out = 12'h000;
        pwdata_out = 32'h0000_0000;
        pstrb_out = 4'h0;
    end
    task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] data,
                        output logic [31:0] rd, output logic err);
        @(posedge clk_in);
        psel_out <= 1'b1;
        penable_out <= 1'b0;
        pwrite_out <= wr;
        paddr_out <= addr;
        pwdata_out <= data;
        pstrb_out <= 4'hF;
        @(posedge clk_in);
        penable_out <= 1'b1;
        @(posedge clk_in);
        while (pready_in !== 1'b1) @(posedge clk_in);
        rd = prdata_in;
        err = pslverr_in;
        psel_out <= 1'b0;
        penable_out <= 1'b0;
        pwdata_out <= ~data;
    endtask
endmodule
`default_nettype wire

// ### tb.sv
// self-checking bench for the special register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
    import sr_pkg::*;
    // ********
    // bench
    // ********
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, irq, soft_rst, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    sr_stat_t stat;
    sr_evt_t evt;
    sr_ctrl_t ctrl;
    int n_mismatch = 0;
    int n_checks = 0;
    int i, r;
    logic [15:0] lfsr = 16'h3112;
    logic [7:0] v;
    // mapped registers only, each used as itself
    logic [7:0] idx_l [12] = '{8'h82, 8'h83, 8'h86, 8'h93, 8'h94, 8'hA2, 8'hAC, 8'hB7,
                               8'hBD, 8'hE0, 8'hEA, 8'hF1};
    logic [7:0] rst_l [12] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00,
                               8'h00, 8'h00, 8'h00, 8'h0E};
    always #5 clk = ~clk;
    sr_bank dut (.MCLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(penable),
        .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PSTRB_IN(pstrb),
        .STAT_IN(stat), .EVT_IN(evt), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(pslverr), .IRQ_OUT(irq), .SOFT_RESET_OUT(soft_rst), .CTRL_OUT(ctrl));
    sr_core_model core (.clk_in(clk), .prdata_in(prdata), .pready_in(pready),
        .pslverr_in(pslverr), .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite),
        .paddr_out(paddr), .pwdata_out(pwdata), .pstrb_out(pstrb));
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [11:0] ba(input logic [7:0] idx);
        ba = {2'b00, idx, 2'b00};
    endfunction
    function automatic logic [7:0] legal(input logic [7:0] idx, input logic [7:0] d);
        case (idx)
            8'hBD: legal = d & 8'h03;
            8'hAC: legal = d & 8'h3D;
            8'hB7: legal = d & 8'h7F;
            8'h94: legal = d & 8'h03;
            8'hA2: legal = d & 8'hF9;
            8'hF1: legal = (d & 8'hB1) | 8'h0E;
            default: legal = d;
        endcase
    endfunction
    function automatic logic [7:0] exp_rd(input logic [7:0] idx, input logic [7:0] d);
        exp_rd = (idx == 8'hA2) ? (d & 8'hF7) : d;
    endfunction
    task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: data %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: flag %b, expected %b", $time, got, exp);
        end
    endtask
    task automatic rd_reg(input logic [11:0] a, input logic [31:0] exp, input logic e);
        core.xfer(1'b0, a, 32'h0000_0000, rd, err);
        chk_data(rd, exp);
        chk_bit(err, e);
    endtask
    task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
        core.xfer(1'b1, a, {24'h00_0000, d}, rd, err);
        chk_bit(err, 1'b0);
    endtask
    task automatic results();
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        lfsr = lfsr_next(lfsr);
        stat = '0;
        stat.two_wire_state = lfsr[7:0];
        stat.capture_a = lfsr;
        evt = '0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        for (i = 0; i < 12; i++) begin
            rd_reg(ba(idx_l[i]), {24'h00_0000, rst_l[i]}, 1'b0);
        end
        rd_reg(ba(8'hD9), {24'h00_0000, stat.two_wire_state & 8'hF8}, 1'b0);
        rd_reg(ba(8'hAB), {24'h00_0000, stat.capture_a[15:8]}, 1'b0);
        for (r = 0; r < 4; r++) begin
            for (i = 0; i < 12; i++) begin
                lfsr = lfsr_next(lfsr);
                v = legal(idx_l[i], lfsr[7:0]);
                wr_reg(ba(idx_l[i]), v);
                rd_reg(ba(idx_l[i]), {24'h00_0000, exp_rd(idx_l[i], v)}, 1'b0);
            end
        end
        wr_reg(ba(8'hA2), 8'hF9);
        #1 chk_bit(soft_rst, 1'b1);
        rd_reg(ba(8'hA2), 32'h0000_00F1, 1'b0);
        chk_bit(ctrl.pointer_select, 1'b1);
        wr_reg(ba(8'hE0), 8'h00);
        core.xfer(1'b1, {2'b01, 8'hE3, 2'b00}, 32'h0000_0001, rd, err);
        chk_bit(err, 1'b0);
        rd_reg(ba(8'hE0), 32'h0000_0008, 1'b0);
        chk_data({24'h00_0000, ctrl.main_arith_register}, 32'h0000_0008);
        rd_reg({2'b01, 8'hE3, 2'b00}, 32'h0000_0001, 1'b0);
        rd_reg({2'b01, 8'hE2, 2'b00}, 32'h0000_0000, 1'b0);
        wr_reg(ba(8'h00), 8'h3F);
        wr_reg(ba(8'h94), 8'h00);
        rd_reg(ba(8'h90), 32'h0000_0000, 1'b1);
        rd_reg({2'b01, 8'h82, 2'b00}, 32'h0000_0000, 1'b1);
        @(posedge clk);
        evt.keypad <= 1'b1;
        @(posedge clk);
        evt.keypad <= 1'b0;
        rd_reg(ba(8'h94), 32'h0000_0001, 1'b0);
        rd_reg(ba(8'h00), 32'h0000_0021, 1'b0);
        wr_reg(ba(8'h01), 8'h01);
        repeat (2) @(posedge clk);
        #1 chk_bit(irq, 1'b1);
        wr_reg(ba(8'h00), 8'h01);
        repeat (2) @(posedge clk);
        #1 chk_bit(irq, 1'b0);
        rd_reg(ba(8'h00), 32'h0000_0020, 1'b0);
        results();
    end
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        results();
    end
endmodule
bind sr_bank sr_bank_props u_props (.MCLK_IN(MCLK_IN), .RST_IN(RST_IN), .PSEL_IN(PSEL_IN),
    .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
    .PWDATA_IN(PWDATA_IN), .PSTRB_IN(PSTRB_IN), .PRDATA_OUT(PRDATA_OUT),
    .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT), .IRQ_OUT(IRQ_OUT),
    .SOFT_RESET_OUT(SOFT_RESET_OUT), .CTRL_OUT(CTRL_OUT));
`default_nettype wire
